// file: design/out_level_cell.v
// one timer output bit: software level, toggle, or follower set/reset with inversion
`timescale 1ns/1ps
module out_level_cell (
	// clock and reset
	input  wire core_clk,
	input  wire resetn,
	// software access
	input  wire sw_write,
	input  wire sw_data,
	// control
	input  wire drive_enable,
	input  wire follower,
	input  wire invert,
	// events
	input  wire own_irq,
	input  wire master_irq,
	input  wire start_pulse,
	input  wire start_toggles,
	// output bit
	output reg  level
);
	reg next_level;
	// choose the next output level from software or timer events
	always @* begin
		next_level = level;
		if (!drive_enable) begin
			if (sw_write)
				next_level = sw_data;
		end else if (follower) begin
			if (own_irq)
				next_level = invert;
			else if (master_irq)
				next_level = ~invert;
		end else if (own_irq | (start_pulse & start_toggles)) begin
			next_level = ~level;
		end
	end
	// output register
	always @(posedge core_clk) begin
		if (!resetn)
			level <= 1'b0;
		else
			level <= next_level;
	end
endmodule

// file: design/run_flag_cell.v
// one run status flag with its one-shot start and stop triggers
`timescale 1ns/1ps
module run_flag_cell (
	// clock and reset
	input  wire core_clk,
	input  wire resetn,
	// triggers from the register port
	input  wire go,
	input  wire halt,
	// state
	output reg  running,
	output reg  start_pulse,
	output reg  stop_pulse
);
	// start wins over a stop in the same write cycle; triggers leave no stored state
	always @(posedge core_clk) begin
		if (!resetn) begin
			running     <= 1'b0;
			start_pulse <= 1'b0;
			stop_pulse  <= 1'b0;
		end else begin
			start_pulse <= go;
			stop_pulse  <= halt & ~go;
			if (go)
				running <= 1'b1;
			else if (halt)
				running <= 1'b0;
		end
	end
endmodule

// file: design/timer_channel_run_and_output_ctrl.v
// run control and output control registers of a four-channel timer unit
`timescale 1ns/1ps
`include "timer_ctrl_defines.vh"
module timer_channel_run_and_output_ctrl #(
	parameter NUM_CHAN = 4
) (
	// clock and reset
	input  wire                 core_clk,
	input  wire                 resetn,
	// register port
	input  wire [`ADDR_W-1:0]   reg_addr,
	input  wire                 reg_wr,
	input  wire                 reg_rd,
	input  wire [7:0]           reg_wdata,
	output reg  [7:0]           reg_rdata,
	// from the counter datapath
	input  wire [NUM_CHAN-1:0]  chan_interrupt_request,
	input  wire [NUM_CHAN-1:0]  split_mode,
	input  wire [NUM_CHAN-1:0]  start_changes_output,
	// to the counter datapath
	output reg  [NUM_CHAN-1:0]  chan_counter_load,
	output reg  [NUM_CHAN-1:0]  upper_counter_load,
	output reg  [NUM_CHAN-1:0]  chan_count_enable,
	output reg  [NUM_CHAN-1:0]  upper_count_enable,
	output reg  [NUM_CHAN-1:0]  chan_stop_event,
	// timer output pins
	output reg  [NUM_CHAN-1:0]  timer_output_pin
);
	// address match helper used by both write and read decode
	function hit;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] b;
		begin
			hit = (a == b);
		end
	endfunction

	// software registers
	reg [NUM_CHAN-1:0] pin_drive_enable;
	reg [NUM_CHAN-1:0] pin_invert_bit;
	reg [NUM_CHAN-1:0] follower_output_select;

	wire [NUM_CHAN-1:0] chan_running_flag;
	wire [NUM_CHAN-1:0] upper_half_running_flag;
	wire [NUM_CHAN-1:0] chan_start_pulse;
	wire [NUM_CHAN-1:0] upper_start_pulse;
	wire [NUM_CHAN-1:0] chan_stop_pulse;
	wire [NUM_CHAN-1:0] upper_stop_pulse;
	wire [NUM_CHAN-1:0] pin_level_bit;
	wire [NUM_CHAN-1:0] master_irq;
	wire [NUM_CHAN-1:0] upper_mask;

	// trigger and output value writes decoded per register
	wire wr_start    = reg_wr & hit(reg_addr, `ADDR_START);
	wire wr_up_start = reg_wr & hit(reg_addr, `ADDR_UP_START);
	wire wr_stop     = reg_wr & hit(reg_addr, `ADDR_STOP);
	wire wr_up_stop  = reg_wr & hit(reg_addr, `ADDR_UP_STOP);
	wire wr_out_val  = reg_wr & hit(reg_addr, `ADDR_OUT_VALUE);

	assign upper_mask = `UPPER_MASK;

	// master of channels 1 and 2 is channel 0, of channel 3 is channel 2; channel 0 has none
	assign master_irq[0] = 1'b0;
	assign master_irq[1] = chan_interrupt_request[0];
	assign master_irq[2] = chan_interrupt_request[0];
	assign master_irq[3] = chan_interrupt_request[2];

	genvar i;
	generate
		for (i = 0; i < NUM_CHAN; i = i + 1) begin : g_chan
			// lower or full run flag; triggers are pulses, never stored
			run_flag_cell u_low (
				.core_clk    (core_clk),
				.resetn      (resetn),
				.go          (wr_start & reg_wdata[i]),
				.halt        (wr_stop & reg_wdata[i]),
				.running     (chan_running_flag[i]),
				.start_pulse (chan_start_pulse[i]),
				.stop_pulse  (chan_stop_pulse[i])
			);
			// upper half flag only exists on channels 1 and 3
			run_flag_cell u_up (
				.core_clk    (core_clk),
				.resetn      (resetn),
				.go          (wr_up_start & reg_wdata[i] & upper_mask[i]),
				.halt        (wr_up_stop & reg_wdata[i] & upper_mask[i]),
				.running     (upper_half_running_flag[i]),
				.start_pulse (upper_start_pulse[i]),
				.stop_pulse  (upper_stop_pulse[i])
			);
			// output bit; software write only lands while output disabled
			out_level_cell u_out (
				.core_clk      (core_clk),
				.resetn        (resetn),
				.sw_write      (wr_out_val),
				.sw_data       (reg_wdata[i]),
				.drive_enable  (pin_drive_enable[i]),
				.follower      (follower_output_select[i]),
				.invert        (pin_invert_bit[i] & follower_output_select[i]),
				.own_irq       (chan_interrupt_request[i]),
				.master_irq    (master_irq[i]),
				.start_pulse   (chan_start_pulse[i]),
				.start_toggles (start_changes_output[i]),
				.level         (pin_level_bit[i])
			);
		end
	endgenerate

	// writable control registers
	always @(posedge core_clk) begin
		if (!resetn) begin
			pin_drive_enable       <= {NUM_CHAN{1'b0}};
			pin_invert_bit         <= {NUM_CHAN{1'b0}};
			follower_output_select <= {NUM_CHAN{1'b0}};
		end else if (reg_wr) begin
			if (hit(reg_addr, `ADDR_OUT_ENABLE))
				pin_drive_enable <= reg_wdata[NUM_CHAN-1:0] & `CHAN_MASK;
			if (hit(reg_addr, `ADDR_OUT_POLARITY))
				pin_invert_bit <= reg_wdata[NUM_CHAN-1:0] & `POLARITY_MASK;
			if (hit(reg_addr, `ADDR_OUT_MODE))
				follower_output_select <= reg_wdata[NUM_CHAN-1:0] & `OUT_MODE_MASK;
		end
	end

	// datapath controls and pin outputs, all registered
	always @(posedge core_clk) begin
		if (!resetn) begin
			chan_counter_load  <= {NUM_CHAN{1'b0}};
			upper_counter_load <= {NUM_CHAN{1'b0}};
			chan_count_enable  <= {NUM_CHAN{1'b0}};
			upper_count_enable <= {NUM_CHAN{1'b0}};
			chan_stop_event    <= {NUM_CHAN{1'b0}};
			timer_output_pin   <= {NUM_CHAN{1'b0}};
		end else begin
			chan_counter_load  <= chan_start_pulse;
			upper_counter_load <= upper_start_pulse & split_mode;
			chan_count_enable  <= chan_running_flag;
			upper_count_enable <= upper_half_running_flag & split_mode;
			chan_stop_event    <= chan_stop_pulse | (upper_stop_pulse & split_mode);
			timer_output_pin   <= pin_level_bit;
		end
	end

	// read data; triggers read zero, status read-only
	always @(posedge core_clk) begin
		if (!resetn) begin
			reg_rdata <= `REG_RESET;
		end else if (reg_rd) begin
			if (hit(reg_addr, `ADDR_RUN_STATUS))
				reg_rdata <= {4'h0, chan_running_flag};
			else if (hit(reg_addr, `ADDR_UP_RUN_STATUS))
				reg_rdata <= {4'h0, upper_half_running_flag & upper_mask};
			else if (hit(reg_addr, `ADDR_OUT_VALUE))
				reg_rdata <= {4'h0, pin_level_bit};
			else if (hit(reg_addr, `ADDR_OUT_ENABLE))
				reg_rdata <= {4'h0, pin_drive_enable};
			else if (hit(reg_addr, `ADDR_OUT_POLARITY))
				reg_rdata <= {4'h0, pin_invert_bit};
			else if (hit(reg_addr, `ADDR_OUT_MODE))
				reg_rdata <= {4'h0, follower_output_select};
			else
				reg_rdata <= 8'h00;
		end
	end
endmodule

// file: design/timer_ctrl_defines.vh
// register map, field layout and reset values of the timer run and output control block
`ifndef TIMER_CTRL_DEFINES_VH
`define TIMER_CTRL_DEFINES_VH
`define ADDR_W             20
`define ADDR_RUN_STATUS    20'hf01b0
`define ADDR_UP_RUN_STATUS 20'hf01b1
`define ADDR_START         20'hf01b2
`define ADDR_UP_START      20'hf01b3
`define ADDR_STOP          20'hf01b4
`define ADDR_UP_STOP       20'hf01b5
`define ADDR_OUT_VALUE     20'hf01b8
`define ADDR_OUT_ENABLE    20'hf01ba
`define ADDR_OUT_POLARITY  20'hf01bc
`define ADDR_OUT_MODE      20'hf01be
`define REG_RESET          8'h00
`define CHAN_MASK          4'hf
`define UPPER_MASK         4'ha
`define POLARITY_MASK      4'he
`define OUT_MODE_MASK      4'he
`define TIME_FILTER_ON_CYC  4
`define TIME_FILTER_OFF_CYC 2
`endif

// file: dv/tb_timer_channel_run_and_output_ctrl.sv
// self-checking bench for the timer run and output control block
`timescale 1ns/1ps
`include "timer_ctrl_defines.vh"
module tb_timer_channel_run_and_output_ctrl;
	reg            core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
	reg  [19:0]    reg_addr = 0;
	reg  [7:0]     reg_wdata = 0, d, got;
	reg  [3:0]     irq = 0, split_mode = 4'ha, sco = 0, e_run = 0, e_up = 0, e_to = 0;
	wire [7:0]     reg_rdata;
	wire [3:0]     pin;
	integer        seed = 32'h56e6, n_mismatch = 0, cmp_count = 0, cyc = 0, i;
	timer_channel_run_and_output_ctrl i_timer_channel_run_and_output_ctrl (
		.core_clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.chan_interrupt_request(irq), .split_mode, .start_changes_output(sco),
		.chan_counter_load(), .upper_counter_load(), .chan_count_enable(),
		.upper_count_enable(), .chan_stop_event(), .timer_output_pin(pin));
	// clock and hang guard
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_mismatch = n_mismatch + 1;
			wrap_up;
		end
	end
	// one register cycle, strobe held for exactly one edge
	task acc(input w, input [19:0] a, input [7:0] v);
		begin
			@(posedge core_clk);
			#1 reg_addr = a;
			reg_wdata = v;
			reg_wr = w;
			reg_rd = !w;
			@(posedge core_clk);
			#1 reg_wr = 0;
			reg_rd = 0;
			got = reg_rdata;
		end
	endtask
	task chk(input [7:0] g, input [7:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("wrong value at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	task wrap_up;
		begin
			if (n_mismatch == 0 && cmp_count > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// main sequence: reset values, random triggers, output control
	initial begin
		repeat (2) @(posedge core_clk);
		#1 resetn = 1;
		acc(0, `ADDR_RUN_STATUS, 0);
		chk(got, `REG_RESET);
		acc(0, `ADDR_UP_RUN_STATUS, 0);
		chk(got, `REG_RESET);
		for (i = 0; i < 60; i = i + 1) begin
			d = $random(seed);
			d[3:0] = d[3:0] & (d[5] ? `UPPER_MASK : `CHAN_MASK);
			case ({d[5], d[4]})
				0: e_run = e_run | d[3:0];
				1: e_run = e_run & ~d[3:0];
				2: e_up = e_up | d[3:0];
				default: e_up = e_up & ~d[3:0];
			endcase
			acc(1, `ADDR_START + {d[4], d[5]}, {4'h0, d[3:0]});
			acc(0, `ADDR_RUN_STATUS, 0);
			chk(got, {4'h0, e_run});
			acc(0, `ADDR_UP_RUN_STATUS, 0);
			chk(got, {4'h0, e_up});
			acc(0, `ADDR_START + {d[4], d[5]}, 0);
			chk(got, 8'h00);
		end
		// mid-run reset returns every channel to stopped
		#1 resetn = 0;
		repeat (2) @(posedge core_clk);
		#1 resetn = 1;
		e_run = 0;
		e_up = 0;
		acc(0, `ADDR_RUN_STATUS, 0);
		chk(got, 8'h00);
		acc(0, `ADDR_UP_RUN_STATUS, 0);
		chk(got, 8'h00);
		for (i = 0; i < 8; i = i + 1) begin
			d = $random(seed);
			e_to = d[3:0];
			acc(1, `ADDR_OUT_VALUE, {4'h0, e_to});
			acc(0, `ADDR_OUT_VALUE, 0);
			chk(got, {4'h0, e_to});
			chk({4'h0, pin}, {4'h0, e_to});
		end
		acc(1, `ADDR_OUT_ENABLE, 8'h01);
		acc(1, `ADDR_OUT_VALUE, {4'h0, ~e_to});
		e_to[3:1] = ~e_to[3:1];
		acc(0, `ADDR_OUT_VALUE, 0);
		chk(got, {4'h0, e_to});
		#1 irq = 4'h1;
		@(posedge core_clk);
		#1 irq = 0;
		e_to[0] = ~e_to[0];
		acc(0, `ADDR_OUT_VALUE, 0);
		chk(got, {4'h0, e_to});
		acc(1, `ADDR_OUT_POLARITY, 8'hff);
		acc(0, `ADDR_OUT_POLARITY, 0);
		chk(got, {4'h0, `POLARITY_MASK});
		// channel 1 as follower with inversion: master event sets low, own event high
		acc(1, `ADDR_OUT_MODE, 8'h02);
		acc(1, `ADDR_OUT_ENABLE, 8'h03);
		#1 irq = 4'h1;
		@(posedge core_clk);
		#1 irq = 0;
		e_to[0] = ~e_to[0];
		e_to[1] = 1'b0;
		acc(0, `ADDR_OUT_VALUE, 0);
		chk(got, {4'h0, e_to});
		#1 irq = 4'h2;
		@(posedge core_clk);
		#1 irq = 0;
		e_to[1] = 1'b1;
		acc(0, `ADDR_OUT_VALUE, 0);
		chk(got, {4'h0, e_to});
		// a start in a mode that changes output toggles the enabled pin
		sco = 4'h1;
		acc(1, `ADDR_START, 8'h01);
		e_to[0] = ~e_to[0];
		acc(0, `ADDR_OUT_VALUE, 0);
		chk(got, {4'h0, e_to});
		// handing the pins back as ports: disable and clear the level bits
		acc(1, `ADDR_OUT_ENABLE, 8'h00);
		acc(1, `ADDR_OUT_VALUE, 8'h00);
		acc(0, `ADDR_OUT_VALUE, 0);
		chk({4'h0, pin}, 8'h00);
		acc(0, 20'hf01bf, 0);
		chk(got, 8'h00);
		wrap_up;
	end
endmodule

// file: dv/timer_ctrl_asserts.sv
// checker for run flags, trigger reads and pin level of the timer control block
`timescale 1ns/1ps
`include "timer_ctrl_defines.vh"
module timer_ctrl_asserts #(
	parameter NUM_CHAN = 4
) (
	// clock and reset
	input wire                core_clk,
	input wire                resetn,
	// register port
	input wire [`ADDR_W-1:0]  reg_addr,
	input wire                reg_wr,
	input wire                reg_rd,
	input wire [7:0]          reg_wdata,
	input wire [7:0]          reg_rdata,
	// datapath and pins
	input wire [NUM_CHAN-1:0] split_mode,
	input wire [NUM_CHAN-1:0] chan_counter_load,
	input wire [NUM_CHAN-1:0] chan_count_enable,
	input wire [NUM_CHAN-1:0] upper_count_enable,
	input wire [NUM_CHAN-1:0] upper_counter_load,
	input wire [NUM_CHAN-1:0] chan_stop_event,
	input wire [NUM_CHAN-1:0] timer_output_pin
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// decoded writes and lone reads
	wire st  = reg_wr && reg_addr == `ADDR_START;
	wire sp  = reg_wr && reg_addr == `ADDR_STOP;
	wire ust = reg_wr && reg_addr == `ADDR_UP_START;
	wire usp = reg_wr && reg_addr == `ADDR_UP_STOP;
	wire rd0 = reg_rd && !reg_wr;
	AST_START_LOAD: assert property (
		st && reg_wdata[0] |-> ##2 chan_counter_load[0]) else $error("no counter reload");
	AST_START_RUN: assert property (
		st && reg_wdata[0] ##1 !reg_wr |-> ##1 chan_count_enable[0]) else $error("not running");
	AST_STOP_HALT: assert property (
		sp && reg_wdata[0] ##1 !reg_wr |-> ##1 !chan_count_enable[0]) else $error("not halted");
	AST_TRIG_READ: assert property (
		rd0 && (reg_addr >= `ADDR_START && reg_addr <= `ADDR_UP_STOP) |=> reg_rdata == 8'h00)
		else $error("trigger read not zero");
	AST_STATUS_READ: assert property (
		rd0 && reg_addr == `ADDR_RUN_STATUS |=> reg_rdata == {4'h0, chan_count_enable[3:0]})
		else $error("status read mismatch");
	AST_PIN_LEVEL: assert property (
		rd0 && reg_addr == `ADDR_OUT_VALUE |=> reg_rdata[3:0] == timer_output_pin[3:0])
		else $error("pin differs from level bit");
	AST_UP_START: assert property (
		ust && reg_wdata[1] && split_mode[1] ##1 !reg_wr && split_mode[1]
		|-> ##1 upper_count_enable[1]) else $error("upper half not running");
	AST_UP_STOP: assert property (
		usp && reg_wdata[1] ##1 !reg_wr |-> ##1 !upper_count_enable[1]
		&& $stable(chan_count_enable[1])) else $error("upper stop wrong");
	AST_STOP_EVENT: assert property (
		sp && reg_wdata[0] |-> ##2 chan_stop_event[0]) else $error("no stop event");
	AST_UP_LOAD: assert property (
		ust && reg_wdata[1] && split_mode[1] |-> ##2 upper_counter_load[1])
		else $error("no upper half reload");
endmodule
bind timer_channel_run_and_output_ctrl timer_ctrl_asserts #(.NUM_CHAN(NUM_CHAN)) i_chk (
	.core_clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .split_mode,
	.chan_counter_load, .chan_count_enable, .upper_count_enable, .upper_counter_load,
	.chan_stop_event, .timer_output_pin);
